// File: pkg/ifd_defs.vh
// constants for the increment file instruction decoder
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH
// ************************************************************
// opcode field instr[15:10], d and a bits instr[9:8]
// ************************************************************
`define IFD_OP_HI 15
`define IFD_OP_LO 10
`define IFD_OP_INC 6'h0a
`define IFD_OP_INCSZ 6'h0f
`define IFD_OP_INCSNZ 6'h12
`define IFD_D_BIT 9
`define IFD_A_BIT 8
// ************************************************************
// addressing
// ************************************************************
`define IFD_IDX_LIMIT 8'h5f
`define IFD_ACC_HI_BASE 4'hf
`define IFD_ACC_LO_BANK 4'h0
`define IFD_RST_BYTE 8'h00
`define IFD_RST_ADDR 12'h000
`define IFD_RST_Q 2'h0
`define IFD_OV_RESULT 8'h80
// ************************************************************
// phases and skip counts
// ************************************************************
`define IFD_PH_READ 2'h1
`define IFD_PH_PROCESS 2'h2
`define IFD_PH_WRITE 2'h3
`define IFD_SKIP_ONE 2'h1
`define IFD_SKIP_TWO 2'h2
`endif

// File: core/ifd_addr_calc.v
// operand address calculation for byte-oriented file operations
`default_nettype none
module ifd_addr_calc
(
  input wire [7:0] f_i,
  input wire a_i,
  input wire ext_en_i,
  input wire [3:0] bank_select_register_i,
  input wire [7:0] fsr2_lo_i,
  input wire [3:0] fsr2_hi_i,
  output wire [11:0] addr_o,
  output wire indexed_o
);
`include "ifd_defs.vh"
  wire [8:0] sum;
  assign indexed_o = ext_en_i & ~a_i & (f_i <= `IFD_IDX_LIMIT);
  // indexed: literal offset added to the index pointer
  assign sum = {1'b0, fsr2_lo_i} + {1'b0, f_i};
  assign addr_o = indexed_o ? {fsr2_hi_i + {3'h0, sum[8]}, sum[7:0]} :
    a_i ? {bank_select_register_i, f_i} :
    (f_i[7] ? {`IFD_ACC_HI_BASE, f_i} : {`IFD_ACC_LO_BANK, f_i});
endmodule
`default_nettype wire

// File: core/ifd_core.v
// decode and execute of the three increment file instructions
// Functional notes
// - opcode 001010 d a f is decoded as a plain increment of file register f.
// - d=0 writes the result to the working register, d=1 back to file register f.
// - a=0 addresses the access bank, a=1 uses the bank select register bank.
// - with extended set on, a=0 and f at most 5fh the operand is indexed literal offset.
// - opcode 001111 increments, stores, keeps flags and skips the next instruction, one or two words, if zero.
// - opcode 010010 increments, stores, keeps flags and skips the next instruction, one or two words, if nonzero.
`default_nettype none
module ifd_core
(
  input wire clk_i,
  input wire nrst_i,
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  input wire next_two_word_i,
  input wire ext_en_i,
  input wire [3:0] bank_select_register_i,
  input wire [7:0] fsr2_lo_i,
  input wire [3:0] fsr2_hi_i,
  input wire [7:0] rdata_i,
  output reg [11:0] addr_o,
  output reg rd_o,
  output reg [7:0] wdata_o,
  output reg wr_file_o,
  output reg wr_w_o,
  output reg flags_we_o,
  output reg [4:0] flags_o,
  output reg skip_o,
  output reg no_operation_o,
  output reg busy_o
);
`include "ifd_defs.vh"
  // ************************************************************
  // decode
  // ************************************************************
  localparam S_IDLE = 2'h0;
  localparam S_EXEC = 2'h1;
  localparam S_NOP = 2'h2;
  // kind codes of the three accepted forms
  localparam K_INC = 2'h0;
  localparam K_SZ = 2'h1;
  localparam K_SNZ = 2'h2;
  // ************************************************************
  // helper functions
  // ************************************************************
  // opcode match, shared by the three decoders
  function op_hit;
    input [5:0] opc;
    input [5:0] code;
    begin
      op_hit = (opc == code);
    end
  endfunction
  // zero test, used by the flags and by both skip forms
  function is_zero_byte;
    input [7:0] b;
    begin
      is_zero_byte = (b == 8'h00);
    end
  endfunction
  // wraps at ffh; the carry is rebuilt from the zero result
  function [7:0] incr_byte;
    input [7:0] b;
    begin
      incr_byte = b + 8'h01;
    end
  endfunction
  // order n ov z dc c; only 7fh to 80h overflows, only ffh to 00h carries
  function [4:0] incr_flags;
    input [7:0] r;
    begin
      incr_flags = {r[7], (r == `IFD_OV_RESULT), is_zero_byte(r), (r[3:0] == 4'h0),
        is_zero_byte(r)};
    end
  endfunction
  // the plain form never skips
  function skip_taken;
    input [1:0] k;
    input [7:0] r;
    begin
      skip_taken = ((k == K_SZ) && is_zero_byte(r)) || ((k == K_SNZ) && !is_zero_byte(r));
    end
  endfunction
  // ************************************************************
  // opcode and operand
  // ************************************************************
  wire [5:0] op = instr_i[`IFD_OP_HI:`IFD_OP_LO];
  wire is_inc = op_hit(op, `IFD_OP_INC);
  wire is_sz = op_hit(op, `IFD_OP_INCSZ);
  wire is_snz = op_hit(op, `IFD_OP_INCSNZ);
  // other opcodes are not ours and pass by untouched
  wire take = instr_valid_i && (is_inc || is_sz || is_snz);
  // worked out combinationally, latched into addr_o at the take
  wire [11:0] calc_addr;
  ifd_addr_calc u_addr
  (
    .f_i(instr_i[7:0]),
    .a_i(instr_i[`IFD_A_BIT]),
    .ext_en_i(ext_en_i),
    .bank_select_register_i(bank_select_register_i),
    .fsr2_lo_i(fsr2_lo_i),
    .fsr2_hi_i(fsr2_hi_i),
    .addr_o(calc_addr),
    .indexed_o()
  );
  // registered decode, kept for the whole instruction
  reg [1:0] state;
  reg [1:0] q;
  reg [1:0] next_q;
  reg [1:0] kind;
  reg dest;
  reg [1:0] nops;
  wire [7:0] sum = incr_byte(rdata_i);
  // ************************************************************
  // phase counter
  // ************************************************************
  // idle parks q; a take starts the read phase, then q wraps each cycle
  always @*
  begin
    next_q = q + 2'h1;
    if (state == S_IDLE)
      next_q = take ? `IFD_PH_READ : q;
  end
  // ************************************************************
  // four-phase execution
  // ************************************************************
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state <= S_IDLE;
      q <= `IFD_RST_Q;
      kind <= 2'h0;
      dest <= 1'b0;
      nops <= 2'h0;
      addr_o <= `IFD_RST_ADDR;
      rd_o <= 1'b0;
      wdata_o <= `IFD_RST_BYTE;
      wr_file_o <= 1'b0;
      wr_w_o <= 1'b0;
      flags_we_o <= 1'b0;
      flags_o <= 5'h00;
      skip_o <= 1'b0;
      no_operation_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      rd_o <= 1'b0;
      wr_file_o <= 1'b0;
      wr_w_o <= 1'b0;
      flags_we_o <= 1'b0;
      skip_o <= 1'b0;
      q <= next_q;
      case (state)
        S_IDLE:
        begin
          no_operation_o <= 1'b0;
          if (take)
          begin
            state <= S_EXEC;
            busy_o <= 1'b1;
            kind <= is_inc ? K_INC : (is_sz ? K_SZ : K_SNZ);
            dest <= instr_i[`IFD_D_BIT];
            // held until the next take so the file side keeps its target
            addr_o <= calc_addr;
            rd_o <= 1'b1;
          end
        end
        S_EXEC:
        begin
          if (q == `IFD_PH_PROCESS)
            wdata_o <= sum;
          if (q == `IFD_PH_WRITE)
          begin
            wr_file_o <= dest;
            wr_w_o <= ~dest;
            // skip forms leave the status flags alone
            if (kind == K_INC)
            begin
              flags_we_o <= 1'b1;
              flags_o <= incr_flags(wdata_o);
            end
            if (skip_taken(kind, wdata_o))
            begin
              skip_o <= 1'b1;
              state <= S_NOP;
              // sampled at q4, when the size of the fetched word is known
              nops <= next_two_word_i ? `IFD_SKIP_TWO : `IFD_SKIP_ONE;
              no_operation_o <= 1'b1;
            end
            else
            begin
              state <= S_IDLE;
              busy_o <= 1'b0;
            end
          end
        end
        S_NOP:
        begin
          // fetched word is dropped; one full q cycle per skipped word
          if (q == `IFD_PH_WRITE)
          begin
            nops <= nops - `IFD_SKIP_ONE;
            if (nops == `IFD_SKIP_ONE)
            begin
              state <= S_IDLE;
              busy_o <= 1'b0;
              no_operation_o <= 1'b0;
            end
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/ifd_core_assertions.sv
// checker for the increment file decoder
`default_nettype none
module ifd_core_chk
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire logic next_two_word_i,
  input wire logic ext_en_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [3:0] fsr2_hi_i,
  input wire logic [7:0] fsr2_lo_i,
  input wire logic [7:0] rdata_i,
  input wire logic [7:0] wdata_o,
  input wire logic [11:0] addr_o,
  input wire logic rd_o,
  input wire logic wr_file_o,
  input wire logic wr_w_o,
  input wire logic flags_we_o,
  input wire logic skip_o,
  input wire logic no_operation_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence take(op);
    !busy_o && instr_valid_i && instr_i[15:10] == op;
  endsequence
  a_inc_dest: assert property (take(6'h0a) |-> ##4 flags_we_o &&
    wr_file_o == $past(instr_i[9], 4) && wr_w_o != $past(instr_i[9], 4)) else $error("bad write");
  a_read_plus_one: assert property (take(6'h0a) |-> ##1 rd_o ##3
    wdata_o == $past(rdata_i, 2) + 8'h01) else $error("bad result");
  a_bank_select: assert property (take(6'h0a) ##0 instr_i[8] |-> ##1
    addr_o == {$past(bank_select_register_i), $past(instr_i[7:0])}) else $error("bad bank");
  a_indexed_addr: assert property (take(6'h0a) ##0 ext_en_i && !instr_i[8] &&
    instr_i[7:0] <= 8'h5f |-> ##1 addr_o == {$past(fsr2_hi_i), $past(fsr2_lo_i)}
    + $past(instr_i[7:0])) else $error("bad index");
  a_skip_zero: assert property (take(6'h0f) |-> ##4
    skip_o == (wdata_o == 8'h00) && !flags_we_o) else $error("bad zero skip");
  a_skip_nonzero: assert property (take(6'h12) |-> ##4
    skip_o == (wdata_o != 8'h00) && !flags_we_o) else $error("bad nonzero skip");
  a_nop_one: assert property (skip_o && !$past(next_two_word_i) |->
    ##1 no_operation_o [*3] ##1 !no_operation_o) else $error("bad nop span");
  a_nop_two: assert property (skip_o && $past(next_two_word_i) |->
    ##1 no_operation_o [*7] ##1 !no_operation_o) else $error("bad long nop span");
endmodule
bind ifd_core ifd_core_chk chk_u (.clk_i, .nrst_i, .instr_valid_i, .next_two_word_i,
  .ext_en_i, .instr_i, .bank_select_register_i, .fsr2_hi_i, .fsr2_lo_i, .rdata_i,
  .wdata_o, .addr_o, .rd_o, .wr_file_o, .wr_w_o, .flags_we_o, .skip_o, .no_operation_o,
  .busy_o);
`default_nettype wire

// File: sim/test_increment_file_ops_decode.sv
// bench for the increment file decoder
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module test_increment_file_ops_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, nrst_i = 1'b0, instr_valid_i = 1'b0, next_two_word_i = 1'b0;
  logic ext_en_i = 1'b0;
  logic [15:0] instr_i = 16'h0;
  logic [3:0] bank_select_register_i = 4'h0, fsr2_hi_i = 4'h1, got;
  logic [7:0] fsr2_lo_i = 8'h10, rdata_i = 8'h0, got_wd;
  logic [11:0] got_addr;
  wire [11:0] addr_o;
  wire [7:0] wdata_o;
  wire [4:0] flags_o;
  wire rd_o, wr_file_o, wr_w_o, flags_we_o, skip_o, no_operation_o, busy_o;
  int bad_count = 0, comparisons = 0;
  int got_n = 0;
  logic got_rd, got_nop;
  ifd_core dut_u (.clk_i, .nrst_i, .instr_i, .instr_valid_i, .next_two_word_i, .ext_en_i,
    .bank_select_register_i, .fsr2_lo_i, .fsr2_hi_i, .rdata_i, .addr_o, .rd_o, .wdata_o,
    .wr_file_o, .wr_w_o, .flags_we_o, .flags_o, .skip_o, .no_operation_o, .busy_o);
  always #25 clk_i = ~clk_i;
  // entered at a falling edge; snapshots decode and write cycles
  task automatic run(input logic [15:0] ins, input logic [7:0] rd);
    int n;
    instr_i = ins;
    rdata_i = rd;
    instr_valid_i = 1'b1;
    @(negedge clk_i) instr_valid_i = 1'b0;
    got_rd = rd_o;
    @(negedge clk_i) got_addr = addr_o;
    // q4 pulses stand one cycle only: look three cycles after the read
    repeat (2) @(negedge clk_i);
    got = {wr_file_o, wr_w_o, flags_we_o, skip_o};
    got_wd = wdata_o;
    got_nop = no_operation_o;
    n = 0;
    while (busy_o !== 1'b0 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    got_n = n;
    `CHK(got_rd, 1'b1)
    `CHK(n < 20, 1'b1)
  endtask
  task t_inc;
    bank_select_register_i = 4'h5;
    run({6'h0a, 2'b11, 8'h34}, 8'hff);
    `CHK(got_addr, 12'h534)
    `CHK(got, 4'b1010)
    `CHK({got_wd, flags_o}, {8'h00, 5'h07})
    `CHK({got_nop, got_n[3:0]}, 5'h00)
    run({6'h0a, 2'b00, 8'h60}, 8'h41);
    `CHK({got_addr, got, got_wd, flags_o}, {12'h060, 4'b0110, 8'h42, 5'h00})
    run({6'h0a, 2'b10, 8'h90}, 8'h7f);
    `CHK({got_addr, got_wd, flags_o}, {12'hf90, 8'h80, 5'h1a})
  endtask
  // index boundary: 5fh indexed, 60h falls back to access bank
  task t_idx;
    ext_en_i = 1'b1;
    run({6'h0a, 2'b00, 8'h5f}, 8'h07);
    `CHK(got_addr, 12'h16f)
    run({6'h0a, 2'b00, 8'h60}, 8'h07);
    `CHK(got_addr, 12'h060)
  endtask
  task t_skip;
    next_two_word_i = 1'b1;
    run({6'h0f, 2'b10, 8'h20}, 8'hff);
    `CHK({got, flags_o}, {4'b1001, 5'h00})
    `CHK(got_addr, 12'h130)
    `CHK({got_nop, got_n[3:0]}, 5'h18)
    run({6'h12, 2'b00, 8'h20}, 8'hff);
    `CHK({got, got_n[3:0]}, {4'b0100, 4'h0})
    next_two_word_i = 1'b0;
    run({6'h12, 2'b10, 8'h20}, 8'h10);
    `CHK({got, got_wd}, {4'b1001, 8'h11})
    `CHK({got_nop, got_n[3:0]}, 5'h14)
  endtask
  task final_report;
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    final_report;
  end
  initial
  begin
    repeat (4) @(negedge clk_i);
    nrst_i = 1'b1;
    t_inc;
    t_idx;
    t_skip;
    final_report;
  end
endmodule
`default_nettype wire
